// ==== sim/ppp_cc_far.sv ====
/* Far-end termination on one port's two CC pins.
   Assumes comparator levels as the guard expects them. */
`timescale 1ns/100ps
module ppp_cc_far (
  // Terminations: 0 open, 1 Ra, 2 Rd
  input wire logic [1:0] i_term1,
  input wire logic [1:0] i_term2,
  // Comparator levels
  output logic o_cc1_below_ra,
  output logic o_cc1_below_dis,
  output logic o_cc2_below_ra,
  output logic o_cc2_below_dis
);
  // ----
  // Pin voltages
  // ----
  // Ra pulls lowest, Rd sits under the disconnect level
  assign o_cc1_below_ra = (i_term1 == 2'h1);
  assign o_cc1_below_dis = (i_term1 != 2'h0);
  assign o_cc2_below_ra = (i_term2 == 2'h1);
  assign o_cc2_below_dis = (i_term2 != 2'h0);
endmodule : ppp_cc_far

// ==== sim/ppp_guard_asserts.sv ====
/* Checker of the guard's protection reactions.
   Assumes the default fault delays of the guard. */
`timescale 1ns/100ps
module ppp_guard_asserts (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Watched inputs
  input wire logic [1:0] i_sw5_hot,
  input wire logic [1:0] i_vconn_hot,
  input wire logic [1:0] i_bus_ovp_hi,
  input wire logic [1:0] i_src_rcp,
  input wire logic [1:0] i_sys_ovp,
  input wire logic [1:0] i_bus_uvlo,
  input wire logic [1:0] i_sink_ovp_enable,
  input wire logic i_rail_uvlo,
  // Watched outputs
  input wire logic [1:0] o_five_volt_source_switch,
  input wire logic [1:0] o_vconn_source_switch_cc1,
  input wire logic [1:0] o_vconn_source_switch_cc2,
  input wire logic [1:0] o_system_sink_gate,
  input wire logic [1:0] o_bus_sink_gate,
  input wire logic [1:0] o_isense_adc_route,
  input wire logic [3:0] o_rp_level,
  input wire logic [1:0] o_error_recovery
);
  // ----
  // Reactions
  // ----
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  a_otemp_err: assert property (
    $rose(i_sw5_hot[0] | i_vconn_hot[0]) |-> ##[1:27] o_error_recovery[0])
    else $error("late error recovery");
  a_src_ovp_off: assert property (
    $rose(i_bus_ovp_hi[0]) && o_five_volt_source_switch[0] |-> ##[1:27] !o_five_volt_source_switch[0])
    else $error("late source ovp");
  a_src_rcp_off: assert property (
    $rose(i_src_rcp[0]) |-> ##[1:27] !o_five_volt_source_switch[0])
    else $error("late source rcp");
  a_vconn_latch: assert property (
    $rose(i_vconn_hot[0]) |-> ##[1:27] (!o_vconn_source_switch_cc1[0] && !o_vconn_source_switch_cc2[0]) [*8])
    else $error("vconn not held off");
  a_vconn_uvlo: assert property (
    $rose(i_rail_uvlo) |-> ##[1:27] (o_vconn_source_switch_cc1 == 2'h0 && o_vconn_source_switch_cc2 == 2'h0))
    else $error("vconn on in uvlo");
  a_sys_fast: assert property (
    $rose(i_sys_ovp[1]) && i_sink_ovp_enable[1] |-> ##[1:6] !o_system_sink_gate[1])
    else $error("late system gate");
  a_bus_gate_off: assert property (
    $rose(i_bus_ovp_hi[1] | i_bus_uvlo[1]) |-> ##[1:27] !o_bus_sink_gate[1])
    else $error("late bus gate");
  a_isense_route: assert property (
    o_isense_adc_route == $past(o_five_volt_source_switch))
    else $error("sense route wrong");
  a_rp_default: assert property (
    !o_five_volt_source_switch[0] && !$past(o_five_volt_source_switch[0]) |-> o_rp_level[1:0] == 2'h0)
    else $error("pull-up not default");
  c_err: cover property ($rose(o_error_recovery[0]));
  c_bus_drop: cover property ($fell(o_bus_sink_gate[1]));
  c_vconn_on: cover property ($rose(o_vconn_source_switch_cc1[0]));
endmodule : ppp_guard_asserts
bind ppp_port_guard ppp_guard_asserts chk_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_sw5_hot(i_sw5_hot), .i_vconn_hot(i_vconn_hot), .i_bus_ovp_hi(i_bus_ovp_hi),
  .i_src_rcp(i_src_rcp), .i_sys_ovp(i_sys_ovp), .i_bus_uvlo(i_bus_uvlo),
  .i_sink_ovp_enable(i_sink_ovp_enable), .i_rail_uvlo(i_rail_uvlo),
  .o_five_volt_source_switch(o_five_volt_source_switch), .o_error_recovery(o_error_recovery),
  .o_vconn_source_switch_cc1(o_vconn_source_switch_cc1), .o_rp_level(o_rp_level),
  .o_vconn_source_switch_cc2(o_vconn_source_switch_cc2), .o_bus_sink_gate(o_bus_sink_gate),
  .o_system_sink_gate(o_system_sink_gate), .o_isense_adc_route(o_isense_adc_route));

// ==== sim/tb_top.sv ====
/* Bench: attach table, source faults, sink gates, boot mode.
   Assumes the far-end model and the checker compiled first. */
`timescale 1ns/100ps
module tb_top;
  import ppp_pkg::*;
  // ----
  // Stimulus, results and model tables
  // ----
  logic clk = 1'b0, rst = 1'b1, boot = 1'b0, lo1 = 1'b0, ra1, ds1, ra2, ds2;
  logic [3:0] flt = 4'h0, s = 4'h0, rp = 4'h0, rpl;
  logic [1:0] t1 = 2'h0, t2 = 2'h0, rcp = 2'h0, frs = 2'h0, snk = 2'h0, sovp = 2'h0;
  logic [1:0] unl = 2'h0, src = 2'h1, sw, v1, v2, sg, bg, dis, isn, w1, w2, err;
  logic [2:0] strap = 3'h5;
  logic [7:0] vmax = 8'h00, ovl;
  logic [15:0] clr = 16'h0000, st;
  ppp_attach_t [1:0] att;
  int mismatches = 0;
  int num_checks = 0;
  int c1s[8] = '{2, 0, 1, 0, 1, 2, 2, 1};
  int c2s[8] = '{0, 2, 0, 1, 2, 1, 2, 1};
  int e[8] = '{9, 17, 24, 24, 19, 13, 24, 24};
  int sb[5] = '{0, 0, 1, 2, 3};
  initial forever #20 clk = ~clk;
  ppp_cc_far far (.i_term1(t1), .i_term2(t2), .o_cc1_below_ra(ra1), .o_cc1_below_dis(ds1),
    .o_cc2_below_ra(ra2), .o_cc2_below_dis(ds2));
  ppp_port_guard #(.CC_CYC(8), .ERR_CYC(16), .SAFE_STRAP_CODE(3'h3)) dut (.i_sys_clk(clk),
    .i_rst(rst), .i_sw5_hot({2{flt[0]}}), .i_vconn_hot({2{flt[1]}}),
    .i_bus_ovp_hi({s[1], flt[2]}), .i_bus_ovp_lo({s[1] | lo1, flt[2]}), .i_src_rcp(rcp),
    .i_sys_ovp({2{s[0]}}), .i_sink_rcp({2{s[2]}}), .i_bus_uvlo({2{s[3]}}),
    .i_cc1_below_ra({2{ra1}}), .i_cc1_below_dis({2{ds1}}), .i_cc2_below_ra({2{ra2}}),
    .i_cc2_below_dis({2{ds2}}), .i_rail_uvlo(flt[3]), .i_boot_mode(boot),
    .i_strap_adc_input(strap), .i_src_enable(src), .i_frs_arm(frs), .i_sink_enable(snk),
    .i_sink_ovp_enable(sovp), .i_rp_select(rp), .i_contract_vmax(vmax),
    .i_vconn_unlatch(unl), .i_status_clear(clr), .o_five_volt_source_switch(sw),
    .o_vconn_source_switch_cc1(v1), .o_vconn_source_switch_cc2(v2), .o_system_sink_gate(sg),
    .o_bus_sink_gate(bg), .o_bus_discharge(dis), .o_isense_adc_route(isn), .o_ovp_level(ovl),
    .o_rp_level(rpl), .o_cc1_watch(w1), .o_cc2_watch(w2), .o_attach_state(att),
    .o_error_recovery(err), .o_status(st));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (6000) @(posedge clk);
    mismatches++;
    final_report;
  end
  initial
  begin
    vmax = 8'($urandom(22243));
    rp = {2'h2, 2'($urandom_range(3, 1))};
    cyc(8);
    rst = 1'b0;
    chk({sw, err}, 4'h0);
    cyc(3);
    chk(dis, 2'h3);
    chk(ovl, vmax);
    for (int i = 0; i < 8; i++)
    begin
      t1 = c1s[i];
      t2 = c2s[i];
      cyc(60);
      chk(att[0], i + 1);
      chk({w2[0], w1[0], v2[0], v1[0], sw[0]}, e[i]);
      chk(rpl[1:0], e[i][0] ? rp[1:0] : 2'h0);
      chk(isn[0], e[i][0]);
      t1 = 2'h0;
      t2 = 2'h0;
      cyc(5);
      chk(att[0], i + 1);
      cyc(15);
      chk({dis[0], att[0]}, 5'h10);
    end
    frs = 2'h2;
    cyc(8);
    chk(sw[1], 1'b1);
    rcp = 2'h2;
    cyc(30);
    chk(sw[1], 1'b0);
    rcp = 2'h0;
    frs = 2'h0;
    t1 = 2'h1;
    t2 = 2'h2;
    cyc(60);
    for (int k = 0; k < 5; k++)
    begin
      if (k < 4)
        flt[k] = 1'b1;
      else
        rcp[0] = 1'b1;
      cyc(30);
      chk({err[0], v1[0], sw[0]}, k == 4 ? 3'h2 : 3'h4);
      chk(st[sb[k]], 1'b1);
      flt = 4'h0;
      rcp = 2'h0;
      cyc(100);
      chk(v1[0], k > 1);
      unl = 2'h3;
      cyc(1);
      unl = 2'h0;
      cyc(60);
      chk({err[0], v1[0], sw[0]}, 3'h3);
      clr = 16'hffff;
      cyc(1);
      clr = 16'h0000;
      cyc(1);
      chk(st[7:0], 8'h00);
    end
    snk = 2'h2;
    sovp = 2'h2;
    cyc(60);
    for (int k = 0; k < 4; k++)
    begin
      s[k] = 1'b1;
      lo1 = (k == 1);
      cyc(30);
      chk(k == 0 ? sg[1] : bg[1], 1'b0);
      chk(st[12 + k], 1'b1);
      s = 4'h0;
      cyc(60);
      chk(bg[1], k != 1);
      lo1 = 1'b0;
      cyc(60);
      chk({sg[1], bg[1]}, 2'h3);
    end
    snk = 2'h0;
    boot = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      strap = k ? 3'h3 : 3'h5;
      s[1] = 1'b1;
      cyc(30);
      chk({sg[1], bg[1]}, 2'h0);
      s = 4'h0;
      cyc(60);
      chk({sg[1], bg[1]}, k ? 2'h0 : 2'h3);
    end
    final_report;
  end
endmodule : tb_top

// ==== src/ppp_consts.svh ====
/*
  Constants for the port power protection and attach detection block:
  input vector layout, status bit positions, reset values and timing.
  Assumes a 40 ns system clock; every count is derived from a time in ns.
*/
// Overview of operation
// - Switch overtemperature kills source switch, error recovery
// - Route source current sense to ADC
// - Contract sets OVP level; overvoltage trips source
// - Rail undervoltage with switch on trips port
// - Reverse current opens source switch, auto recloses
// - Armed fast swap closes switch when not reversed
// - VCONN switch clamps current, no reverse blocking
// - Overtemperature latches VCONN off, error recovery
// - Rail undervoltage opens both VCONN switches
// - Sink OVP enabled drops system gate fast
// - Bus overvoltage drops bus gate, hysteretic return
// - Boot mode OVP holds gates; safe strap keeps off
// - System rail reverse current drops bus gate
// - Bus undervoltage drops bus gate, auto return
// - Unattached port discharges bus
// - Single Rd powers bus; open-open applies nothing
// - Ra plus open: no power, watch both
// - Ra plus Rd: bus and VCONN on Ra
// - Rd-Rd debug, Ra-Ra audio, either detaches
// - Default pull-up until source switch closes
// - Low Ra-range voltage means active cable
// - Detach only after full debounce above threshold
`ifndef PPP_CONSTS_SVH
`define PPP_CONSTS_SVH

// ----------------------------------------------------------------
// Per-port comparator input layout
// ----------------------------------------------------------------
`define PPP_IN_SW5_HOT 0
`define PPP_IN_VCN_HOT 1
`define PPP_IN_OVP_HI 2
`define PPP_IN_OVP_LO 3
`define PPP_IN_SRC_RCP 4
`define PPP_IN_SRC_RCPF 5
`define PPP_IN_SYS_OVP 6
`define PPP_IN_SNK_RCP 7
`define PPP_IN_BUS_UVLO 8
`define PPP_IN_CC1_RA 9
`define PPP_IN_CC1_DIS 10
`define PPP_IN_CC2_RA 11
`define PPP_IN_CC2_DIS 12
`define PPP_IN_W 13

// ----------------------------------------------------------------
// Status bit positions per port
// ----------------------------------------------------------------
`define PPP_ST_OTEMP 0
`define PPP_ST_SRC_OVP 1
`define PPP_ST_SRC_UVLO 2
`define PPP_ST_SRC_RCP 3
`define PPP_ST_SYS_OVP 4
`define PPP_ST_BUS_OVP 5
`define PPP_ST_SNK_RCP 6
`define PPP_ST_BUS_UVLO 7
`define PPP_ST_W 8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PPP_RP_DEF 2'h0
`define PPP_SAFE_STRAP 3'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PPP_CLK_PERIOD_NS 40
`define PPP_T_OTSD_NS 1000
`define PPP_T_SRC_OVP_NS 1000
`define PPP_T_SRC_UVLO_NS 1000
`define PPP_T_SRC_RCP_NS 1000
`define PPP_T_ON_NS 2000
`define PPP_T_FRS_ON_NS 200
`define PPP_T_SYS_FSD_NS 200
`define PPP_T_BUS_OVP_NS 1000
`define PPP_T_BUS_RCP_NS 1000
`define PPP_T_BUS_ON_NS 2000
`define PPP_T_CC_NS 150000
`define PPP_T_ERR_REC_NS 25000000
// Longest time: floor, minus sync and output stages, at least 1
`define PPP_CYC_DN(t) ((((t) / `PPP_CLK_PERIOD_NS) > 4) ? (((t) / `PPP_CLK_PERIOD_NS) - 3) : 1)
// Least time: ceiling
`define PPP_CYC_UP(t) (((t) + `PPP_CLK_PERIOD_NS - 1) / `PPP_CLK_PERIOD_NS)

`endif

// ==== src/ppp_pkg.sv ====
/*
  Types for the port power protection and attach detection block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ppp_pkg;

  typedef enum logic [1:0] {PPP_CC_OPEN, PPP_CC_RA, PPP_CC_RD} ppp_cc_class_t;

  typedef enum logic [3:0] {
    PPP_ATT_NONE, PPP_ATT_SNK1, PPP_ATT_SNK2, PPP_ATT_CBL1, PPP_ATT_CBL2,
    PPP_ATT_PWR1, PPP_ATT_PWR2, PPP_ATT_DBG, PPP_ATT_AUD
  } ppp_attach_t;

  typedef enum logic [1:0] {PPP_ST_UNATT, PPP_ST_ATT, PPP_ST_ERR} ppp_port_state_t;

endpackage : ppp_pkg

// ==== src/ppp_port_guard.sv ====
/*
  Two-port supervisory logic: source, VCONN and sink path protection,
  error recovery and source-mode attach decoding from the CC pins.
  Assumes analog comparators on the pins; all of them are asynchronous.
*/
`timescale 1ns/100ps
`include "ppp_consts.svh"
module ppp_port_guard #(
  parameter int unsigned OTSD_CYC = `PPP_CYC_DN(`PPP_T_OTSD_NS),
  parameter int unsigned SRC_OVP_CYC = `PPP_CYC_DN(`PPP_T_SRC_OVP_NS),
  parameter int unsigned SRC_UVLO_CYC = `PPP_CYC_DN(`PPP_T_SRC_UVLO_NS),
  parameter int unsigned SRC_RCP_CYC = `PPP_CYC_DN(`PPP_T_SRC_RCP_NS),
  parameter int unsigned ON_CYC = `PPP_CYC_DN(`PPP_T_ON_NS),
  parameter int unsigned FRS_CYC = `PPP_CYC_DN(`PPP_T_FRS_ON_NS),
  parameter int unsigned SYS_FSD_CYC = `PPP_CYC_DN(`PPP_T_SYS_FSD_NS),
  parameter int unsigned BUS_OVP_CYC = `PPP_CYC_DN(`PPP_T_BUS_OVP_NS),
  parameter int unsigned BUS_RCP_CYC = `PPP_CYC_DN(`PPP_T_BUS_RCP_NS),
  parameter int unsigned BUS_ON_CYC = `PPP_CYC_DN(`PPP_T_BUS_ON_NS),
  parameter int unsigned CC_CYC = `PPP_CYC_UP(`PPP_T_CC_NS),
  parameter int unsigned ERR_CYC = `PPP_CYC_UP(`PPP_T_ERR_REC_NS),
  parameter logic [2:0] SAFE_STRAP_CODE = `PPP_SAFE_STRAP
) (
  // Clock and reset
  input logic i_sys_clk,
  input logic i_rst,
  // Comparators, per port
  input logic [1:0] i_sw5_hot,
  input logic [1:0] i_vconn_hot,
  input logic [1:0] i_bus_ovp_hi,
  input logic [1:0] i_bus_ovp_lo,
  input logic [1:0] i_src_rcp,
  input logic [1:0] i_sys_ovp,
  input logic [1:0] i_sink_rcp,
  input logic [1:0] i_bus_uvlo,
  input logic [1:0] i_cc1_below_ra,
  input logic [1:0] i_cc1_below_dis,
  input logic [1:0] i_cc2_below_ra,
  input logic [1:0] i_cc2_below_dis,
  // Shared supply monitors
  input logic i_rail_uvlo,
  input logic i_boot_mode,
  input logic [2:0] i_strap_adc_input,
  // Firmware control, per port
  input logic [1:0] i_src_enable,
  input logic [1:0] i_frs_arm,
  input logic [1:0] i_sink_enable,
  input logic [1:0] i_sink_ovp_enable,
  input logic [3:0] i_rp_select,
  input logic [7:0] i_contract_vmax,
  input logic [1:0] i_vconn_unlatch,
  input logic [15:0] i_status_clear,
  // Power path drive
  output logic [1:0] o_five_volt_source_switch,
  output logic [1:0] o_vconn_source_switch_cc1,
  output logic [1:0] o_vconn_source_switch_cc2,
  output logic [1:0] o_system_sink_gate,
  output logic [1:0] o_bus_sink_gate,
  output logic [1:0] o_bus_discharge,
  output logic [1:0] o_isense_adc_route,
  output logic [7:0] o_ovp_level,
  // CC pin control
  output logic [3:0] o_rp_level,
  output logic [1:0] o_cc1_watch,
  output logic [1:0] o_cc2_watch,
  // Status
  output ppp_pkg::ppp_attach_t [1:0] o_attach_state,
  output logic [1:0] o_error_recovery,
  output logic [15:0] o_status
);
  import ppp_pkg::*;

  localparam int unsigned NQ = 2 * `PPP_IN_W + 2;
  localparam int unsigned SET_TAB [`PPP_IN_W] = '{
    OTSD_CYC, OTSD_CYC, BUS_OVP_CYC, 1, SRC_RCP_CYC, SRC_RCP_CYC,
    SYS_FSD_CYC, BUS_RCP_CYC, BUS_RCP_CYC, 1, 1, 1, 1};
  localparam int unsigned CLR_TAB [`PPP_IN_W] = '{
    1, 1, 1, BUS_ON_CYC, ON_CYC, FRS_CYC,
    1, BUS_ON_CYC, BUS_ON_CYC, 1, 1, 1, 1};

  logic [NQ-1:0] raw;
  logic [NQ-1:0] q;
  logic rail_uvlo_q;
  logic boot_q;
  logic safe_strap;

  // ----------------------------------------------------------------
  // Input synchronisation and qualification
  // ----------------------------------------------------------------
  assign raw = {i_boot_mode, i_rail_uvlo,
                i_cc2_below_dis[1], i_cc2_below_ra[1], i_cc1_below_dis[1],
                i_cc1_below_ra[1], i_bus_uvlo[1], i_sink_rcp[1], i_sys_ovp[1],
                i_src_rcp[1], i_src_rcp[1], i_bus_ovp_lo[1], i_bus_ovp_hi[1],
                i_vconn_hot[1], i_sw5_hot[1],
                i_cc2_below_dis[0], i_cc2_below_ra[0], i_cc1_below_dis[0],
                i_cc1_below_ra[0], i_bus_uvlo[0], i_sink_rcp[0], i_sys_ovp[0],
                i_src_rcp[0], i_src_rcp[0], i_bus_ovp_lo[0], i_bus_ovp_hi[0],
                i_vconn_hot[0], i_sw5_hot[0]};

  for (genvar g = 0; g < NQ; g++)
  begin : g_qual
    localparam int unsigned IX = g % `PPP_IN_W;
    localparam int unsigned SC = (g >= 2 * `PPP_IN_W) ? SRC_UVLO_CYC : SET_TAB[IX];
    localparam int unsigned CC = (g >= 2 * `PPP_IN_W) ? 1 : CLR_TAB[IX];
    ppp_qual #(
      .SET_CYC(SC),
      .CLR_CYC(CC)
    ) u_qual (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_raw(raw[g]),
      .o_level(q[g])
    );
  end

  assign rail_uvlo_q = q[2 * `PPP_IN_W];
  assign boot_q = q[2 * `PPP_IN_W + 1];
  assign safe_strap = (i_strap_adc_input == SAFE_STRAP_CODE);

  // ----------------------------------------------------------------
  // Pin classification and attach decode
  // ----------------------------------------------------------------
  function automatic ppp_cc_class_t cc_class(input logic below_ra, input logic below_dis);
    ppp_cc_class_t c;
    c = PPP_CC_OPEN;
    if (below_ra)
      c = PPP_CC_RA;
    else if (below_dis)
      c = PPP_CC_RD;
    return c;
  endfunction : cc_class

  function automatic ppp_attach_t attach_decode(input ppp_cc_class_t c1,
                                                input ppp_cc_class_t c2);
    ppp_attach_t a;
    a = PPP_ATT_NONE;
    case ({c1, c2})
      {PPP_CC_RD, PPP_CC_OPEN}: a = PPP_ATT_SNK1;
      {PPP_CC_OPEN, PPP_CC_RD}: a = PPP_ATT_SNK2;
      {PPP_CC_RA, PPP_CC_OPEN}: a = PPP_ATT_CBL1;
      {PPP_CC_OPEN, PPP_CC_RA}: a = PPP_ATT_CBL2;
      {PPP_CC_RA, PPP_CC_RD}: a = PPP_ATT_PWR1;
      {PPP_CC_RD, PPP_CC_RA}: a = PPP_ATT_PWR2;
      {PPP_CC_RD, PPP_CC_RD}: a = PPP_ATT_DBG;
      {PPP_CC_RA, PPP_CC_RA}: a = PPP_ATT_AUD;
      default: a = PPP_ATT_NONE;
    endcase
    return a;
  endfunction : attach_decode

  // ----------------------------------------------------------------
  // Per-port supervisor
  // ----------------------------------------------------------------
  for (genvar p = 0; p < 2; p++)
  begin : g_port
    localparam int unsigned B = p * `PPP_IN_W;

    ppp_port_state_t state_ff;
    ppp_attach_t attach_ff;
    logic [$clog2(CC_CYC + 1)-1:0] det_cnt_ff;
    logic [$clog2(ERR_CYC + 1)-1:0] err_cnt_ff;
    logic sw5_ff, vcn1_ff, vcn2_ff, vlock_ff;
    logic sys_gate_ff, bus_gate_ff, dsch_ff, isense_ff;
    logic ovp_state_ff, cc1w_ff, cc2w_ff, err_ff;
    logic [1:0] rp_ff;
    logic [3:0] ovp_lvl_ff;
    logic [`PPP_ST_W-1:0] st_ff;
    logic [`PPP_ST_W-1:0] ev;
    ppp_cc_class_t c1, c2;
    ppp_attach_t dec;
    logic hot, src_ovp, src_uvlo, fault, detach, power_att, boot_hold, gate_req;

    assign c1 = cc_class(q[B + `PPP_IN_CC1_RA], q[B + `PPP_IN_CC1_DIS]);
    assign c2 = cc_class(q[B + `PPP_IN_CC2_RA], q[B + `PPP_IN_CC2_DIS]);
    assign dec = attach_decode(c1, c2);
    assign hot = q[B + `PPP_IN_SW5_HOT] | q[B + `PPP_IN_VCN_HOT];
    assign src_ovp = sw5_ff & q[B + `PPP_IN_OVP_HI];
    assign src_uvlo = sw5_ff & rail_uvlo_q;
    assign fault = hot | src_ovp | src_uvlo;

    // Detach condition for the Rd pin, a cable's Ra pin, or either pin of debug and audio
    always_comb
    begin
      detach = 1'b0;
      case (attach_ff)
        PPP_ATT_SNK1, PPP_ATT_CBL1, PPP_ATT_PWR2: detach = (c1 == PPP_CC_OPEN);
        PPP_ATT_SNK2, PPP_ATT_CBL2, PPP_ATT_PWR1: detach = (c2 == PPP_CC_OPEN);
        PPP_ATT_DBG, PPP_ATT_AUD: detach = (c1 == PPP_CC_OPEN) | (c2 == PPP_CC_OPEN);
        default: detach = 1'b0;
      endcase
    end

    assign power_att = (state_ff == PPP_ST_ATT) & i_src_enable[p] &
                       (attach_ff == PPP_ATT_SNK1 | attach_ff == PPP_ATT_SNK2 |
                        attach_ff == PPP_ATT_PWR1 | attach_ff == PPP_ATT_PWR2);

    // ----------------------------------------------------------------
    // Connection state
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk)
    begin
      if (i_rst)
      begin
        state_ff <= PPP_ST_UNATT;
        attach_ff <= PPP_ATT_NONE;
        err_ff <= 1'b0;
      end
      else
      begin
        err_ff <= (state_ff == PPP_ST_ERR) ?
                  (err_cnt_ff < $bits(err_cnt_ff)'(ERR_CYC - 1)) : fault;
        case (state_ff)
          PPP_ST_UNATT:
          begin
            if (fault)
              state_ff <= PPP_ST_ERR;
            else if (dec != PPP_ATT_NONE)
            begin
              state_ff <= PPP_ST_ATT;
              attach_ff <= dec;
            end
          end
          PPP_ST_ATT:
          begin
            if (fault)
            begin
              state_ff <= PPP_ST_ERR;
              attach_ff <= PPP_ATT_NONE;
            end
            else if (detach && det_cnt_ff >= $bits(det_cnt_ff)'(CC_CYC - 1))
            begin
              state_ff <= PPP_ST_UNATT;
              attach_ff <= PPP_ATT_NONE;
            end
            else if ((attach_ff == PPP_ATT_CBL1 && dec == PPP_ATT_PWR1) ||
                     (attach_ff == PPP_ATT_CBL2 && dec == PPP_ATT_PWR2))
              attach_ff <= dec;
          end
          PPP_ST_ERR:
          begin
            attach_ff <= PPP_ATT_NONE;
            if (err_cnt_ff >= $bits(err_cnt_ff)'(ERR_CYC - 1))
              state_ff <= PPP_ST_UNATT;
          end
          default:
          begin
            state_ff <= PPP_ST_UNATT;
            attach_ff <= PPP_ATT_NONE;
          end
        endcase
      end
    end

    // Detach debounce
    always_ff @(posedge i_sys_clk)
    begin
      if (i_rst || !detach || state_ff != PPP_ST_ATT)
        det_cnt_ff <= '0;
      else if (det_cnt_ff < $bits(det_cnt_ff)'(CC_CYC - 1))
        det_cnt_ff <= det_cnt_ff + 1'b1;
    end

    // Error recovery dwell
    always_ff @(posedge i_sys_clk)
    begin
      if (i_rst || state_ff != PPP_ST_ERR)
        err_cnt_ff <= '0;
      else
        err_cnt_ff <= err_cnt_ff + 1'b1;
    end

    // ----------------------------------------------------------------
    // Source path
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk)
    begin
      if (i_rst)
      begin
        sw5_ff <= 1'b0;
        isense_ff <= 1'b0;
        ovp_lvl_ff <= '0;
      end
      else
      begin
        sw5_ff <= !fault && state_ff != PPP_ST_ERR &&
                  ((power_att && !q[B + `PPP_IN_SRC_RCP]) ||
                   (i_frs_arm[p] && !q[B + `PPP_IN_SRC_RCPF]));
        isense_ff <= sw5_ff;
        ovp_lvl_ff <= i_contract_vmax[p*4 +: 4];
      end
    end

    // VCONN switches; the current clamp is analog and never blocks reverse flow
    always_ff @(posedge i_sys_clk)
    begin
      if (i_rst)
      begin
        vlock_ff <= 1'b0;
        vcn1_ff <= 1'b0;
        vcn2_ff <= 1'b0;
      end
      else
      begin
        vlock_ff <= hot | (vlock_ff & ~i_vconn_unlatch[p]);
        vcn1_ff <= power_att && attach_ff == PPP_ATT_PWR1 &&
                   !vlock_ff && !hot && !rail_uvlo_q;
        vcn2_ff <= power_att && attach_ff == PPP_ATT_PWR2 &&
                   !vlock_ff && !hot && !rail_uvlo_q;
      end
    end

    // ----------------------------------------------------------------
    // Sink path
    // ----------------------------------------------------------------
    assign boot_hold = boot_q & (ovp_state_ff | q[B + `PPP_IN_OVP_HI] | safe_strap);
    assign gate_req = boot_q | i_sink_enable[p];

    always_ff @(posedge i_sys_clk)
    begin
      if (i_rst)
        ovp_state_ff <= 1'b0;
      else if (q[B + `PPP_IN_OVP_HI])
        ovp_state_ff <= 1'b1;
      else if (!q[B + `PPP_IN_OVP_LO])
        ovp_state_ff <= 1'b0;
    end

    always_ff @(posedge i_sys_clk)
    begin
      if (i_rst)
      begin
        sys_gate_ff <= 1'b0;
        bus_gate_ff <= 1'b0;
      end
      else
      begin
        sys_gate_ff <= gate_req && !boot_hold &&
                       !(i_sink_ovp_enable[p] && q[B + `PPP_IN_SYS_OVP]);
        bus_gate_ff <= gate_req && !boot_hold &&
                       !ovp_state_ff && !q[B + `PPP_IN_OVP_HI] &&
                       !q[B + `PPP_IN_SNK_RCP] &&
                       !q[B + `PPP_IN_BUS_UVLO];
      end
    end

    // ----------------------------------------------------------------
    // CC pin control and discharge
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk)
    begin
      if (i_rst)
      begin
        dsch_ff <= 1'b0;
        rp_ff <= `PPP_RP_DEF;
        cc1w_ff <= 1'b0;
        cc2w_ff <= 1'b0;
      end
      else
      begin
        dsch_ff <= (state_ff == PPP_ST_UNATT);
        rp_ff <= sw5_ff ? i_rp_select[p*2 +: 2] : `PPP_RP_DEF;
        cc1w_ff <= !(attach_ff == PPP_ATT_SNK2 || attach_ff == PPP_ATT_PWR1);
        cc2w_ff <= !(attach_ff == PPP_ATT_SNK1 || attach_ff == PPP_ATT_PWR2);
      end
    end

    // ----------------------------------------------------------------
    // Sticky event flags, set wins over clear
    // ----------------------------------------------------------------
    assign ev[`PPP_ST_OTEMP] = hot;
    assign ev[`PPP_ST_SRC_OVP] = src_ovp;
    assign ev[`PPP_ST_SRC_UVLO] = src_uvlo;
    assign ev[`PPP_ST_SRC_RCP] = q[B + `PPP_IN_SRC_RCP];
    assign ev[`PPP_ST_SYS_OVP] = i_sink_ovp_enable[p] & q[B + `PPP_IN_SYS_OVP];
    assign ev[`PPP_ST_BUS_OVP] = q[B + `PPP_IN_OVP_HI];
    assign ev[`PPP_ST_SNK_RCP] = q[B + `PPP_IN_SNK_RCP];
    assign ev[`PPP_ST_BUS_UVLO] = q[B + `PPP_IN_BUS_UVLO];

    always_ff @(posedge i_sys_clk)
    begin
      if (i_rst)
        st_ff <= '0;
      else
        st_ff <= (st_ff & ~i_status_clear[p*8 +: 8]) | ev;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_five_volt_source_switch[p] = sw5_ff;
    assign o_vconn_source_switch_cc1[p] = vcn1_ff;
    assign o_vconn_source_switch_cc2[p] = vcn2_ff;
    assign o_system_sink_gate[p] = sys_gate_ff;
    assign o_bus_sink_gate[p] = bus_gate_ff;
    assign o_bus_discharge[p] = dsch_ff;
    assign o_isense_adc_route[p] = isense_ff;
    assign o_ovp_level[p*4 +: 4] = ovp_lvl_ff;
    assign o_rp_level[p*2 +: 2] = rp_ff;
    assign o_cc1_watch[p] = cc1w_ff;
    assign o_cc2_watch[p] = cc2w_ff;
    assign o_attach_state[p] = attach_ff;
    assign o_error_recovery[p] = err_ff;
    assign o_status[p*8 +: 8] = st_ff;
  end

endmodule : ppp_port_guard

// ==== src/ppp_qual.sv ====
/*
  Two-flop synchroniser followed by an asymmetric qualification filter.
  Assumes an asynchronous raw level and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module ppp_qual #(
  parameter int unsigned SET_CYC = 1,
  parameter int unsigned CLR_CYC = 1
) (
  // Clock and reset
  input logic i_sys_clk,
  input logic i_rst,
  // Level
  input logic i_raw,
  output logic o_level
);

  localparam int unsigned MAXC = (SET_CYC > CLR_CYC) ? SET_CYC : CLR_CYC;
  localparam int unsigned CW = $clog2(MAXC + 1);

  logic meta_ff;
  logic sync_ff;
  logic level_ff;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] need;

  assign need = sync_ff ? CW'(SET_CYC - 1) : CW'(CLR_CYC - 1);
  assign o_level = level_ff;

  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= i_raw;
      sync_ff <= meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Qualification
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      level_ff <= 1'b0;
      cnt_ff <= '0;
    end
    else if (sync_ff == level_ff)
      cnt_ff <= '0;
    else if (cnt_ff >= need)
    begin
      level_ff <= sync_ff;
      cnt_ff <= '0;
    end
    else
      cnt_ff <= cnt_ff + 1'b1;
  end

endmodule : ppp_qual
